// ==== core/sprt_pkg.sv ====
// Purpose: Shared constants and types for the serial port front end
// Assumes: Byte-wide register port, eight register offsets
// Notes:   Offsets are register indices on the plain port

package sprt_pkg;
    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [2:0] OFS_DATA  = 3'h0;
    localparam logic [2:0] OFS_IER   = 3'h1;
    localparam logic [2:0] OFS_FIFO  = 3'h2;
    localparam logic [2:0] OFS_LCR   = 3'h3;
    localparam logic [2:0] OFS_MCR   = 3'h4;
    localparam logic [2:0] OFS_LSR   = 3'h5;
    localparam logic [2:0] OFS_MSR   = 3'h6;
    localparam logic [2:0] OFS_SCR   = 3'h7;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int LCR_DIV_SEL   = 7;
    localparam int FCR_ENABLE    = 0;
    localparam int FCR_CLR_RX    = 1;
    localparam int FCR_CLR_TX    = 2;
    localparam int FCR_TRIG_LO   = 6;
    localparam int FCR_TRIG_HI   = 7;
    // ****************************************
    // Reset values and counts
    // ****************************************
    localparam logic [7:0]  RST_BYTE    = 8'h00;
    localparam logic [15:0] RST_DIVISOR = 16'h0001;
    localparam logic [3:0]  TICK_MID    = 4'h7;
    localparam logic [3:0]  TICK_END    = 4'hF;
    localparam logic [9:0]  TOUT_TICKS  = 10'h280;
    localparam logic [4:0]  TRIG_1      = 5'h01;
    localparam logic [4:0]  TRIG_4      = 5'h04;
    localparam logic [4:0]  TRIG_8      = 5'h08;
    localparam logic [4:0]  TRIG_14     = 5'h0E;
    // Identification values
    localparam logic [3:0]  ID_NONE = 4'h1;
    localparam logic [3:0]  ID_LINE = 4'h6;
    localparam logic [3:0]  ID_RXD  = 4'h4;
    localparam logic [3:0]  ID_TOUT = 4'hC;
    localparam logic [3:0]  ID_THRE = 4'h2;
    localparam logic [3:0]  ID_MDM  = 4'h0;
    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        SH_IDLE  = 2'h0,
        SH_START = 2'h1,
        SH_DATA  = 2'h3,
        SH_STOP  = 2'h2
    } sprt_shift_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [2:0] addr;
        logic [7:0] wdata;
    } sprt_bus_t;
endpackage

// ==== core/sprt_uart.sv ====
// Purpose: Serial port holding, shift, enable and FIFO control logic
// Assumes: Fixed 8 data bits, 1 stop bit, no parity; 16 ticks per bit
// Notes:   Modem register is plain storage here; LCR bit 7 selects the divisor, which sets the tick rate
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/10ps

module sprt_uart #(
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    // Clock and reset
    input  wire logic              i_clk_sys,
    input  wire logic              i_rstn,
    // Register port
    input  wire sprt_pkg::sprt_bus_t i_bus,
    output logic [7:0]             o_rdata,
    // Serial line and straps
    input  wire logic              i_serial_rx,
    input  wire logic              i_legacy_pc_mode,
    input  wire logic              i_modem_change,
    output logic                   o_serial_tx,
    output logic                   o_irq
);
    import sprt_pkg::*;

    // ****************************************
    // Input synchronisers
    // ****************************************
    logic rx_s1, rx_s2, leg_s1, leg_s2;
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            rx_s1  <= 1'b1;
            rx_s2  <= 1'b1;
            leg_s1 <= 1'b0;
            leg_s2 <= 1'b0;
        end else begin
            rx_s1  <= i_serial_rx;
            rx_s2  <= rx_s1;
            leg_s1 <= i_legacy_pc_mode;
            leg_s2 <= leg_s1;
        end
    end

    // ****************************************
    // Decode
    // ****************************************
    logic [3:0]   interrupt_enable_mask;
    logic [7:0]   lcr, mcr, scr, dll, dlm;
    logic         fifo_en;
    logic [1:0]   trig;
    logic         dsel;
    assign dsel = lcr[LCR_DIV_SEL];
    logic wr_thr, wr_ier, wr_fcr, rd_rbr, rd_iir, rd_lsr, rd_msr;
    assign wr_thr = i_bus.wr && i_bus.addr == OFS_DATA && !dsel;
    assign wr_ier = i_bus.wr && i_bus.addr == OFS_IER && !dsel;
    assign wr_fcr = i_bus.wr && i_bus.addr == OFS_FIFO;
    assign rd_rbr = i_bus.rd && i_bus.addr == OFS_DATA && !dsel;
    assign rd_iir = i_bus.rd && i_bus.addr == OFS_FIFO;
    assign rd_lsr = i_bus.rd && i_bus.addr == OFS_LSR;
    assign rd_msr = i_bus.rd && i_bus.addr == OFS_MSR;

    // Mode change or clear bit empties a FIFO; DMA bit 3 is never looked at
    logic rx_flush, tx_flush;
    assign rx_flush = wr_fcr && (fifo_en != i_bus.wdata[FCR_ENABLE]
                      || (i_bus.wdata[FCR_ENABLE] && i_bus.wdata[FCR_CLR_RX]));
    assign tx_flush = wr_fcr && (fifo_en != i_bus.wdata[FCR_ENABLE]
                      || (i_bus.wdata[FCR_ENABLE] && i_bus.wdata[FCR_CLR_TX]));

    // ****************************************
    // Software registers
    // ****************************************
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            interrupt_enable_mask <= 4'h0;
            lcr <= RST_BYTE;
            mcr <= RST_BYTE;
            scr <= RST_BYTE;
            dll <= RST_DIVISOR[7:0];
            dlm <= RST_DIVISOR[15:8];
        end else if (i_bus.wr) begin
            case (i_bus.addr)
                OFS_DATA: if (dsel) dll <= i_bus.wdata;
                OFS_IER: begin
                    if (dsel) dlm <= i_bus.wdata;
                    else interrupt_enable_mask <= i_bus.wdata[3:0];
                end
                OFS_LCR: lcr <= i_bus.wdata;
                OFS_MCR: mcr <= i_bus.wdata;
                OFS_SCR: if (!leg_s2) scr <= i_bus.wdata;
                default: ;
            endcase
        end
    end

    // Clear bits are never stored, so they read back as self-cleared
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            fifo_en <= 1'b0;
            trig    <= 2'h0;
        end else if (wr_fcr) begin
            fifo_en <= i_bus.wdata[FCR_ENABLE];
            if (i_bus.wdata[FCR_ENABLE]) trig <= i_bus.wdata[FCR_TRIG_HI:FCR_TRIG_LO];
        end
    end

    // ****************************************
    // Bit rate ticks (16 per bit)
    // ****************************************
    logic [15:0] bcnt, div;
    logic        tick;
    assign div  = ({dlm, dll} == 16'h0000) ? 16'h0001 : {dlm, dll};
    assign tick = (bcnt == div - 16'h0001);
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) bcnt <= 16'h0000;
        else bcnt <= tick ? 16'h0000 : bcnt + 16'h0001;
    end

    // ****************************************
    // Receive shifter and FIFO
    // ****************************************
    sprt_shift_t rx_st;
    logic [3:0]  rx_sub;
    logic [2:0]  rx_bit;
    logic [7:0]  rx_sh;
    logic        rx_done, rx_fe;
    logic [7:0]  rx_mem [DEPTH];
    logic [AW-1:0] rx_wp, rx_rp;
    logic [AW:0]   rx_cnt, cap;
    logic        rx_push, rx_pop;
    assign cap = fifo_en ? (AW+1)'(DEPTH) : (AW+1)'(1);
    assign rx_done = rx_st == SH_STOP && tick && rx_sub == TICK_END;
    assign rx_push = rx_done && rx_cnt != cap;
    assign rx_pop  = rd_rbr && rx_cnt != '0;
    assign rx_fe   = !rx_s2;

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            rx_st  <= SH_IDLE;
            rx_sub <= 4'h0;
            rx_bit <= 3'h0;
            rx_sh  <= RST_BYTE;
        end else begin
            case (rx_st)
                SH_IDLE: begin
                    rx_sub <= 4'h0;
                    if (!rx_s2) rx_st <= SH_START;
                end
                SH_START: if (tick) begin
                    rx_sub <= rx_sub + 4'h1;
                    if (rx_sub == TICK_MID) begin
                        rx_sub <= 4'h0;
                        rx_bit <= 3'h0;
                        rx_st  <= rx_s2 ? SH_IDLE : SH_DATA;
                    end
                end
                SH_DATA: if (tick) begin
                    rx_sub <= rx_sub + 4'h1;
                    if (rx_sub == TICK_END) begin
                        rx_sh  <= {rx_s2, rx_sh[7:1]};
                        rx_bit <= rx_bit + 3'h1;
                        if (rx_bit == 3'h7) rx_st <= SH_STOP;
                    end
                end
                SH_STOP: if (tick) begin
                    rx_sub <= rx_sub + 4'h1;
                    if (rx_sub == TICK_END) rx_st <= SH_IDLE;
                end
                default: rx_st <= SH_IDLE;
            endcase
        end
    end

    // Flush touches only pointers and counters, never the storage or the shifter
    always_ff @(posedge i_clk_sys) begin
        if (rx_push) rx_mem[rx_wp] <= rx_sh;
    end
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            rx_wp  <= '0;
            rx_rp  <= '0;
            rx_cnt <= '0;
        end else if (rx_flush) begin
            rx_wp  <= '0;
            rx_rp  <= '0;
            rx_cnt <= '0;
        end else begin
            if (rx_push) rx_wp <= rx_wp + 1'b1;
            if (rx_pop) rx_rp <= rx_rp + 1'b1;
            rx_cnt <= rx_cnt + (AW+1)'(rx_push) - (AW+1)'(rx_pop);
        end
    end

    // ****************************************
    // Transmit FIFO and shifter
    // ****************************************
    sprt_shift_t tx_st;
    logic [3:0]  tx_sub;
    logic [2:0]  tx_bit;
    logic [7:0]  tx_sh;
    logic [7:0]  tx_mem [DEPTH];
    logic [AW-1:0] tx_wp, tx_rp;
    logic [AW:0]   tx_cnt;
    logic        tx_push, tx_pop, thre, transmitter_idle_flag;
    // A slot freed by a same-cycle shifter load takes back-to-back writes
    assign tx_push = wr_thr && (tx_cnt != cap || tx_pop);
    assign tx_pop  = tx_st == SH_IDLE && tx_cnt != '0 && !tx_flush;
    assign thre    = tx_cnt == '0;
    assign transmitter_idle_flag    = (tx_st == SH_IDLE) && (leg_s2 || thre);

    always_ff @(posedge i_clk_sys) begin
        if (tx_push) tx_mem[tx_wp] <= i_bus.wdata;
    end
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            tx_wp  <= '0;
            tx_rp  <= '0;
            tx_cnt <= '0;
        end else if (tx_flush) begin
            tx_wp  <= '0;
            tx_rp  <= '0;
            tx_cnt <= '0;
        end else begin
            if (tx_push) tx_wp <= tx_wp + 1'b1;
            if (tx_pop) tx_rp <= tx_rp + 1'b1;
            tx_cnt <= tx_cnt + (AW+1)'(tx_push) - (AW+1)'(tx_pop);
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            tx_st  <= SH_IDLE;
            tx_sub <= 4'h0;
            tx_bit <= 3'h0;
            tx_sh  <= RST_BYTE;
        end else begin
            case (tx_st)
                SH_IDLE: if (tx_pop) begin
                    tx_sh  <= tx_mem[tx_rp];
                    tx_sub <= 4'h0;
                    tx_bit <= 3'h0;
                    tx_st  <= SH_START;
                end
                SH_START: if (tick) begin
                    tx_sub <= tx_sub + 4'h1;
                    if (tx_sub == TICK_END) tx_st <= SH_DATA;
                end
                SH_DATA: if (tick) begin
                    tx_sub <= tx_sub + 4'h1;
                    if (tx_sub == TICK_END) begin
                        tx_sh  <= {1'b0, tx_sh[7:1]};
                        tx_bit <= tx_bit + 3'h1;
                        if (tx_bit == 3'h7) tx_st <= SH_STOP;
                    end
                end
                SH_STOP: if (tick) begin
                    tx_sub <= tx_sub + 4'h1;
                    if (tx_sub == TICK_END) tx_st <= SH_IDLE;
                end
                default: tx_st <= SH_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) o_serial_tx <= 1'b1;
        else o_serial_tx <= (tx_st == SH_START) ? 1'b0 :
                            (tx_st == SH_DATA) ? tx_sh[0] : 1'b1;
    end

    // ****************************************
    // Status flags and interrupt sources
    // ****************************************
    // Hardware set beats a same-cycle read clear
    logic oe, fe, bi, thre_q, thre_pend, ms_pend, tout;
    logic [9:0] tout_cnt;
    logic thre_set;
    assign thre_set = (thre && !thre_q) || (wr_ier && i_bus.wdata[1] && !interrupt_enable_mask[1] && thre);
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            oe <= 1'b0;
            fe <= 1'b0;
            bi <= 1'b0;
        end else begin
            oe <= (rx_done && rx_cnt == cap) || (oe && !rd_lsr);
            fe <= (rx_done && rx_fe) || (fe && !rd_lsr);
            bi <= (rx_done && rx_fe && rx_sh == 8'h00) || (bi && !rd_lsr);
        end
    end

    logic [3:0] iid;
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            thre_q    <= 1'b1;
            thre_pend <= 1'b0;
            ms_pend   <= 1'b0;
        end else begin
            thre_q    <= thre;
            thre_pend <= thre_set || (thre_pend && !wr_thr && !(rd_iir && iid == ID_THRE));
            ms_pend   <= i_modem_change || (ms_pend && !rd_msr);
        end
    end

    // Four character times of silence with data waiting
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) tout_cnt <= 10'h000;
        else if (!fifo_en || rx_cnt == '0 || rx_push || rx_pop) tout_cnt <= 10'h000;
        else if (tick && tout_cnt != TOUT_TICKS) tout_cnt <= tout_cnt + 10'h001;
    end
    assign tout = tout_cnt == TOUT_TICKS;

    logic [4:0] lvl;
    always_comb begin
        case (trig)
            2'h0:    lvl = TRIG_1;
            2'h1:    lvl = TRIG_4;
            2'h2:    lvl = TRIG_8;
            default: lvl = TRIG_14;
        endcase
    end

    logic line_irq, rxd_irq, tout_irq, thre_irq, mdm_irq;
    assign line_irq = interrupt_enable_mask[2] && (oe || fe || bi);
    assign rxd_irq  = interrupt_enable_mask[0] && (fifo_en ? rx_cnt >= lvl : rx_cnt != '0);
    assign tout_irq = interrupt_enable_mask[0] && fifo_en && tout;
    assign thre_irq = interrupt_enable_mask[1] && thre_pend;
    assign mdm_irq  = interrupt_enable_mask[3] && ms_pend;
    always_comb begin
        if (line_irq) iid = ID_LINE;
        else if (rxd_irq) iid = ID_RXD;
        else if (tout_irq) iid = ID_TOUT;
        else if (thre_irq) iid = ID_THRE;
        else if (mdm_irq) iid = ID_MDM;
        else iid = ID_NONE;
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) o_irq <= 1'b0;
        else o_irq <= iid != ID_NONE;
    end

    // ****************************************
    // Read data, one cycle after the strobe
    // ****************************************
    logic [7:0] next_rdata;
    always_comb begin
        case (i_bus.addr)
            OFS_DATA: next_rdata = dsel ? dll : (rx_cnt != '0 ? rx_mem[rx_rp] : 8'h00);
            OFS_IER:  next_rdata = dsel ? dlm : {4'h0, interrupt_enable_mask};
            OFS_FIFO: next_rdata = {fifo_en, fifo_en, 2'h0, iid};
            OFS_LCR:  next_rdata = lcr;
            OFS_MCR:  next_rdata = mcr;
            OFS_LSR:  next_rdata = {fifo_en && (fe || bi), transmitter_idle_flag, thre, bi, fe, 1'b0, oe,
                                    rx_cnt != '0};
            OFS_SCR:  next_rdata = leg_s2 ? 8'h00 : scr;
            default:  next_rdata = 8'h00;
        endcase
    end
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) o_rdata <= 8'h00;
        else o_rdata <= i_bus.rd ? next_rdata : 8'h00;
    end

    // ****************************************
    // Assertions
    // ****************************************
    property p_div_read;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (i_bus.rd && i_bus.addr == OFS_DATA && dsel) |=> o_rdata == $past(dll);
    endproperty
    a_div_read: assert property (p_div_read) else $error("divisor latch not read");
    property p_lsb_first;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (tx_st == SH_START && tick && tx_sub == TICK_END) |=> ##1 o_serial_tx == $past(tx_sh[0]);
    endproperty
    a_lsb_first: assert property (p_lsb_first) else $error("first data bit not bit 0");
    property p_legacy_idle;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (rd_lsr && leg_s2 && tx_st == SH_IDLE) |=> o_rdata[6];
    endproperty
    a_legacy_idle: assert property (p_legacy_idle) else $error("idle flag missing");
    property p_no_scratch;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (i_bus.rd && i_bus.addr == OFS_SCR && leg_s2) |=> o_rdata == 8'h00;
    endproperty
    a_no_scratch: assert property (p_no_scratch) else $error("scratch visible");
    property p_fifo_bits;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (rd_iir && !fifo_en) |=> o_rdata[7:6] == 2'h0 && !o_rdata[3];
    endproperty
    a_fifo_bits: assert property (p_fifo_bits) else $error("FIFO bits set");
    property p_ier_rsv;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (i_bus.rd && i_bus.addr == OFS_IER && !dsel) |=> o_rdata[7:4] == 4'h0;
    endproperty
    a_ier_rsv: assert property (p_ier_rsv) else $error("reserved bits set");
    property p_irq_off;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (interrupt_enable_mask == 4'h0) |=> !o_irq;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq while disabled");
    property p_tx_reload;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        tx_pop |-> tx_st == SH_IDLE ##1 tx_st == SH_START;
    endproperty
    a_tx_reload: assert property (p_tx_reload) else $error("early shifter load");
    property p_disable_flush;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (wr_fcr && fifo_en && !i_bus.wdata[FCR_ENABLE]) |=> rx_cnt == '0 && tx_cnt == '0;
    endproperty
    a_disable_flush: assert property (p_disable_flush) else $error("FIFOs kept");
    property p_rx_clear;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (wr_fcr && i_bus.wdata[FCR_ENABLE] && i_bus.wdata[FCR_CLR_RX]
         && !(tick && rx_sub == TICK_END))
        |=> rx_cnt == '0 && rx_sh == $past(rx_sh);
    endproperty
    a_rx_clear: assert property (p_rx_clear) else $error("rx clear failed");
    property p_tx_clear;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (wr_fcr && i_bus.wdata[FCR_ENABLE] && i_bus.wdata[FCR_CLR_TX]
         && !(tick && tx_sub == TICK_END))
        |=> tx_cnt == '0 && tx_st == $past(tx_st);
    endproperty
    a_tx_clear: assert property (p_tx_clear) else $error("tx clear failed");
    c_rx_char: cover property (@(posedge i_clk_sys) rx_push);
    c_tx_load: cover property (@(posedge i_clk_sys) tx_pop ##1 tx_cnt != '0);
    c_tout:    cover property (@(posedge i_clk_sys) tout_irq);
    c_full:    cover property (@(posedge i_clk_sys) fifo_en && rx_cnt == cap);
endmodule

// ==== test/sprt_line_model.sv ====
// Purpose: Serial line partner, 8N1 at 16 clocks per bit
// Assumes: Divisor of 1, line idles high
// Notes:   Bytes seen on the design's output queue up in got
`timescale 1ns/10ps
module sprt_line_model (
    input  wire logic i_clk_sys,
    input  wire logic i_tx,
    output logic      o_rx
);
    logic [7:0] got[$];
    logic [7:0] sh;
    initial o_rx = 1'b1;
    // Start, data LSB first, stop
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge i_clk_sys);
            o_rx <= f[i];
            repeat (15) @(posedge i_clk_sys);
        end
    endtask
    // Sample mid-bit after the start edge
    initial forever begin
        @(negedge i_tx);
        repeat (8) @(posedge i_clk_sys);
        for (int i = 0; i < 8; i++) begin
            repeat (16) @(posedge i_clk_sys);
            sh[i] = i_tx;
        end
        repeat (16) @(posedge i_clk_sys);
        got.push_back(sh);
    end
endmodule

// ==== test/testbench.sv ====
// Purpose: Self-checking bench for the serial port front end
// Assumes: Divisor left at 1, 16 clocks per bit
// Notes:   Random bytes from a fixed seed, corner cases by hand
`timescale 1ns/10ps
module testbench;
    import sprt_pkg::*;
    logic       i_clk_sys = 1'b0;
    logic       i_rstn    = 1'b0;
    sprt_bus_t  i_bus     = '0;
    logic [7:0] o_rdata, rd, b0, b1;
    logic       o_serial_tx, o_irq, i_serial_rx;
    logic       mchg      = 1'b0;
    logic       leg       = 1'b0;
    int         n_fail = 0, total_checks = 0, cyc = 0, seed = 32'hcada00c1;
    always #25 i_clk_sys = ~i_clk_sys;
    sprt_uart i_dut (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_bus(i_bus),
        .o_rdata(o_rdata), .i_serial_rx(i_serial_rx), .i_legacy_pc_mode(leg),
        .i_modem_change(mchg), .o_serial_tx(o_serial_tx), .o_irq(o_irq));
    sprt_line_model i_line (.i_clk_sys(i_clk_sys), .i_tx(o_serial_tx), .o_rx(i_serial_rx));
    // ****
    // Bus tasks and checks
    // ****
    function automatic logic [7:0] iir_exp(input logic fen, input logic [3:0] id);
        return {fen, fen, 2'b00, id};
    endfunction
    task automatic chk(input string w, input logic [7:0] s, input logic [7:0] e);
        total_checks++;
        if (s !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", w, e, s);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        i_bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge i_clk_sys);
        i_bus <= '0;
    endtask
    task automatic rchk(input string w, input logic [2:0] a, input logic [7:0] e);
        @(posedge i_clk_sys);
        i_bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge i_clk_sys);
        i_bus <= '0;
        #1 rd = o_rdata;
        chk(w, rd, e);
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Hang guard, well above the expected run
    always @(posedge i_clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            close_out();
        end
    end
    initial begin
        repeat (3) @(posedge i_clk_sys);
        i_rstn <= 1'b1;
        rchk("ier", OFS_IER, RST_BYTE);
        rchk("iir", OFS_FIFO, iir_exp(1'b0, ID_NONE));
        wr(OFS_IER, 8'hF0);
        rchk("ier_res", OFS_IER, 8'h00);
        wr(OFS_LCR, 8'h80);
        wr(OFS_DATA, 8'h01);
        rchk("div_lo", OFS_DATA, 8'h01);
        wr(OFS_LCR, 8'h00);
        $display("test regs done");
        for (int k = 0; k < 3; k++) begin
            b0 = $random(seed);
            i_line.send(b0);
            repeat (4) @(posedge i_clk_sys);
            rchk("rx", OFS_DATA, b0);
            b0 = $random(seed);
            b1 = $random(seed);
            wr(OFS_DATA, b0);
            wr(OFS_DATA, b1);
            repeat (400) @(posedge i_clk_sys);
            chk("tx0", i_line.got.pop_front(), b0);
            chk("tx1", i_line.got.pop_front(), b1);
        end
        $display("test serial done");
        wr(OFS_FIFO, 8'h09);
        rchk("iir_fen", OFS_FIFO, iir_exp(1'b1, ID_NONE));
        for (int j = 0; j < 2; j++) begin
            wr(OFS_FIFO, 8'h01);
            i_line.send($random(seed));
            repeat (4) @(posedge i_clk_sys);
            wr(OFS_FIFO, j ? 8'h03 : 8'h00);
            rchk("dr", OFS_LSR, 8'h60);
        end
        wr(OFS_FIFO, 8'h00);
        rchk("iir_off", OFS_FIFO, iir_exp(1'b0, ID_NONE));
        $display("test fifo done");
        // Second byte overruns the single holding slot
        wr(OFS_IER, 8'h05);
        b0 = $random(seed);
        b1 = $random(seed);
        i_line.send(b0);
        i_line.send(b1);
        repeat (4) @(posedge i_clk_sys);
        rchk("iir_line", OFS_FIFO, iir_exp(1'b0, ID_LINE));
        rchk("lsr_oe", OFS_LSR, 8'h63);
        rchk("iir_rxd", OFS_FIFO, iir_exp(1'b0, ID_RXD));
        rchk("rx_kept", OFS_DATA, b0);
        // One byte stays below a threshold of four
        wr(OFS_FIFO, 8'h41);
        i_line.send(b1);
        repeat (4) @(posedge i_clk_sys);
        rchk("iir_trig", OFS_FIFO, iir_exp(1'b1, ID_NONE));
        rchk("rx_fifo", OFS_DATA, b1);
        wr(OFS_FIFO, 8'h00);
        $display("test line done");
        wr(OFS_IER, 8'h02);
        repeat (4) @(negedge i_clk_sys);
        chk("irq_thre", {7'h00, o_irq}, 8'h01);
        rchk("iir_thre", OFS_FIFO, iir_exp(1'b0, ID_THRE));
        wr(OFS_IER, 8'h08);
        mchg <= 1'b1;
        @(posedge i_clk_sys);
        mchg <= 1'b0;
        repeat (4) @(posedge i_clk_sys);
        rchk("iir_mdm", OFS_FIFO, iir_exp(1'b0, ID_MDM));
        wr(OFS_IER, 8'h00);
        repeat (4) @(negedge i_clk_sys);
        chk("irq_off", {7'h00, o_irq}, 8'h00);
        wr(OFS_SCR, 8'h5A);
        leg <= 1'b1;
        repeat (4) @(posedge i_clk_sys);
        rchk("scr_leg", OFS_SCR, 8'h00);
        rchk("lsr_leg", OFS_LSR, 8'h60);
        wr(OFS_SCR, 8'hA5);
        leg <= 1'b0;
        repeat (4) @(posedge i_clk_sys);
        rchk("scr", OFS_SCR, 8'h5A);
        $display("test irq done");
        close_out();
    end
endmodule
